// [hdl/lcc_cluster_map.vh]
// Offsets, field positions, codes and reset values of the logic cluster
`ifndef LCC_CLUSTER_MAP_VH
`define LCC_CLUSTER_MAP_VH

// Cluster geometry
`define LCC_NCELLS      10
`define LCC_ADDR_W      5
`define LCC_DATA_W      32
`define LCC_CFG_W       24

// Register word indices
`define LCC_ADDR_CFG0   5'h00
`define LCC_ADDR_STAT   5'h10

// Cell configuration word fields
`define LCC_LUT_LSB     0
`define LCC_LUT_MSB     15
`define LCC_MODE_LSB    16
`define LCC_MODE_MSB    17
`define LCC_USECIN_BIT  18
`define LCC_PACK_BIT    19
`define LCC_CESEL_BIT   20
`define LCC_CASCEN_BIT  21
`define LCC_FBEN_BIT    22
`define LCC_CINFRC_BIT  23

// Status word fields
`define LCC_STAT_REG_LSB   0
`define LCC_STAT_CARRY_BIT 16
`define LCC_STAT_CASC_BIT  17

// Operating mode codes
`define LCC_MODE_NORMAL  2'h0
`define LCC_MODE_ARITH   2'h1
`define LCC_MODE_COUNTER 2'h2

// Reset values
`define LCC_CFG_RST     24'h000000
`define LCC_RDATA_RST   32'h00000000

`endif

// [hdl/lcc_regs.v]
// Configuration and status register file of the logic cluster
`timescale 1ns/1ns
`include "lcc_cluster_map.vh"

module lcc_regs #(
   parameter NCELLS = `LCC_NCELLS
) (
   // Clock and reset
   input  wire                          sys_clk,
   input  wire                          nrst,
   input  wire                          clkEn,
   // Register port
   input  wire [`LCC_ADDR_W-1:0]        regAddr,
   input  wire [`LCC_DATA_W-1:0]        regWdata,
   input  wire                          regWr,
   input  wire                          regRd,
   output reg  [`LCC_DATA_W-1:0]        regRdata,
   // Cluster side
   output wire [NCELLS*`LCC_CFG_W-1:0]  cfgFlat,
   input  wire [`LCC_DATA_W-1:0]        statusWord
);

   wire [`LCC_DATA_W-1:0] rdOr [0:NCELLS];

   ////////////////////////////////////////////////////////////////////////
   // Per-cell configuration words
   assign rdOr[0] = (regAddr == `LCC_ADDR_STAT) ? statusWord :
                    `LCC_RDATA_RST;

   genvar i;
   generate
      for (i = 0; i < NCELLS; i = i + 1) begin : gCfg
         localparam integer IDXW = `LCC_ADDR_CFG0 + i;
         localparam [`LCC_ADDR_W-1:0] IDX = IDXW[`LCC_ADDR_W-1:0];
         reg [`LCC_CFG_W-1:0] cfg_q;
         always @(posedge sys_clk) begin
            if (!nrst) begin
               cfg_q <= `LCC_CFG_RST;
            end else if (clkEn && regWr && regAddr == IDX) begin
               cfg_q <= regWdata[`LCC_CFG_W-1:0];
            end
         end
         assign cfgFlat[i*`LCC_CFG_W +: `LCC_CFG_W] = cfg_q;
         assign rdOr[i+1] = rdOr[i] | ((regAddr == IDX) ?
            {{(`LCC_DATA_W-`LCC_CFG_W){1'b0}}, cfg_q} :
            `LCC_RDATA_RST);
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Read data, one cycle after the strobe, zero otherwise
   always @(posedge sys_clk) begin
      if (!nrst) begin
         regRdata <= `LCC_RDATA_RST;
      end else if (clkEn) begin
         regRdata <= regRd ? rdOr[NCELLS] : `LCC_RDATA_RST;
      end
   end

endmodule // lcc_regs

// [hdl/lcc_cluster.v]
// Logic cluster of programmable cells with carry and cascade chains
//
// What this block does
// RULE1 - Normal mode: 4-input table, third input is input c or carry-in.
// RULE2 - Normal mode table result may be ANDed into the outgoing cascade.
// RULE3 - Normal mode packs register from input d unless carry-in is used.
// RULE4 - Two cluster-wide clock enables; each cell selects one of them.
// RULE5 - Only the first cell may feed its own register back into logic.
// RULE6 - Inputs a,b carry count enable, direction, feedback; not cell two.
// RULE7 - Cluster clear and load hit every cell register whose selected enable is high.
// RULE8 - Arithmetic mode splits table into two 3-input halves.
// RULE9 - Arithmetic sum half uses a, b and carry-in; comb or registered.
// RULE10 - Arithmetic carry half drives next cell carry-in, ripple chain.
// RULE11 - Cascade chain stays usable together with the carry chain.
// RULE12 - Registered and unregistered result are driven out together.
// RULE13 - Counter has clock enable, count enable, up/down, clear, load.
// RULE14 - Counter enable and direction come from cell data inputs.
// RULE15 - Counter cluster holds only that counter or combinational cells.
// RULE16 - Cascade joins neighbours with AND; OR via inverted terms.
// RULE17 - Cell register updates only while its selected enable is high.
// RULE18 - Clear beats load, load beats counting, counting needs enable.
`timescale 1ns/1ns
`include "lcc_cluster_map.vh"

module lcc_cluster #(
   parameter NCELLS = `LCC_NCELLS
) (
   // Clock, reset and global freeze
   input  wire                      sys_clk,
   input  wire                      nrst,
   input  wire                      clkEn,
   // Register port
   input  wire [`LCC_ADDR_W-1:0]    regAddr,
   input  wire [`LCC_DATA_W-1:0]    regWdata,
   input  wire                      regWr,
   input  wire                      regRd,
   output wire [`LCC_DATA_W-1:0]    regRdata,
   // Cluster-wide controls
   input  wire [1:0]                clusterCe,
   input  wire                      syncClr,
   input  wire                      syncLoad,
   // Cell data inputs from local routing
   input  wire [NCELLS-1:0]         cellInputA,
   input  wire [NCELLS-1:0]         cellInputB,
   input  wire [NCELLS-1:0]         cellInputC,
   input  wire [NCELLS-1:0]         cellInputD,
   // Chains from the previous cluster
   input  wire                      carryIn,
   input  wire                      cascadeIn,
   // Cell results
   output wire [NCELLS-1:0]         cellComb,
   output wire [NCELLS-1:0]         cellReg,
   // Chains to the next cluster
   output wire                      carryOut,
   output wire                      cascadeOut
);

   wire [NCELLS*`LCC_CFG_W-1:0] cfgFlat;
   wire [`LCC_DATA_W-1:0]       statusWord;
   wire [NCELLS:0]              carryVec;
   wire [NCELLS:0]              cascVec;
   wire [15:0]                  regPad;

   ////////////////////////////////////////////////////////////////////////
   // Register file
   lcc_regs #(
      .NCELLS (NCELLS)
   ) uRegs (
      .sys_clk    (sys_clk),
      .nrst       (nrst),
      .clkEn      (clkEn),
      .regAddr    (regAddr),
      .regWdata   (regWdata),
      .regWr      (regWr),
      .regRd      (regRd),
      .regRdata   (regRdata),
      .cfgFlat    (cfgFlat),
      .statusWord (statusWord)
   );

   ////////////////////////////////////////////////////////////////////////
   // Status word: register outputs and chain ends
   assign regPad = {{(16-NCELLS){1'b0}}, cellReg};
   assign statusWord = {14'h0000, cascVec[NCELLS], carryVec[NCELLS],
                        regPad};

   ////////////////////////////////////////////////////////////////////////
   // Chain ends
   assign carryVec[0] = carryIn;
   assign cascVec[0]  = cascadeIn;
   assign carryOut    = carryVec[NCELLS];
   assign cascadeOut  = cascVec[NCELLS];

   ////////////////////////////////////////////////////////////////////////
   // Logic cells
   genvar i;
   generate
      for (i = 0; i < NCELLS; i = i + 1) begin : gCell
         // Feedback mux exists only in the first cell
         localparam HAS_FB  = (i == 0);
         // Cell two cannot take control signals on inputs a and b
         localparam CTRL_OK = (i != 1);

         wire [`LCC_CFG_W-1:0] cfg;
         wire [15:0]           lutMask;
         wire [1:0]            mode;
         wire                  useCin;
         wire                  packEn;
         wire                  cascEn;
         wire                  fbEn;
         wire                  cinEff;
         wire                  inA;
         wire                  inB;
         wire                  inC;
         wire                  inD;
         wire [3:0]            lutIdx;
         wire [2:0]            arIdx;
         wire                  lutOut;
         wire                  sumOut;
         wire                  arCarry;
         wire                  cntEn;
         wire                  cntUp;
         wire                  cntCarry;
         wire                  cntNext;
         wire                  selCe;
         wire                  cascOut;
         reg                   funcOut;
         reg                   carryOutC;
         reg                   regD;
         reg                   cell_q;

         assign cfg     = cfgFlat[i*`LCC_CFG_W +: `LCC_CFG_W];
         assign lutMask = cfg[`LCC_LUT_MSB:`LCC_LUT_LSB];
         assign mode    = cfg[`LCC_MODE_MSB:`LCC_MODE_LSB];
         assign useCin  = cfg[`LCC_USECIN_BIT];
         assign packEn  = cfg[`LCC_PACK_BIT];
         assign cascEn  = cfg[`LCC_CASCEN_BIT];
         assign fbEn    = cfg[`LCC_FBEN_BIT];

         // Forced carry starts a chain at this cell
         assign cinEff  = cfg[`LCC_CINFRC_BIT] | carryVec[i];

         // Input a replaced by own register output
         assign inA = (HAS_FB && fbEn) ? cell_q : cellInputA[i]; // [RULE5]
         assign inB = cellInputB[i];
         assign inC = cellInputC[i];
         assign inD = cellInputD[i];

         // Normal mode table
         assign lutIdx = {inD, (useCin ? cinEff : inC), inB, inA}; // [RULE1]
         assign lutOut = lutMask[lutIdx]; // [RULE1]

         // Arithmetic mode halves
         assign arIdx   = {cinEff, inB, inA}; // [RULE9]
         assign sumOut  = lutMask[{1'b0, arIdx}]; // [RULE8] [RULE9]
         assign arCarry = lutMask[{1'b1, arIdx}]; // [RULE8] [RULE10]

         // Counter controls from data inputs
         assign cntEn    = CTRL_OK ? inA : 1'b1; // [RULE6] [RULE14]
         assign cntUp    = CTRL_OK ? inB : 1'b1; // [RULE6] [RULE14]
         assign cntNext  = cell_q ^ (cntEn & cinEff); // [RULE13] [RULE18]
         assign cntCarry = cntEn & cinEff & (cntUp ? cell_q : ~cell_q);

         // Mode result and carry selection
         always @* begin
            case (mode)
               `LCC_MODE_NORMAL: begin
                  funcOut   = lutOut;
                  carryOutC = 1'b0;
               end
               `LCC_MODE_ARITH: begin
                  funcOut   = sumOut;
                  carryOutC = arCarry; // [RULE10]
               end
               `LCC_MODE_COUNTER: begin
                  funcOut   = cntNext;
                  carryOutC = cntCarry; // [RULE13]
               end
               default: begin
                  funcOut   = lutOut;
                  carryOutC = 1'b0;
               end
            endcase
         end

         // Cascade AND, usable in every mode
         assign cascOut = cascEn ? (funcOut & cascVec[i]) // [RULE16] [RULE11]
                                 : funcOut; // [RULE2]

         assign cascVec[i+1]  = cascOut; // [RULE2]
         assign carryVec[i+1] = carryOutC; // [RULE10]

         // Register data selection
         always @* begin
            case (mode)
               `LCC_MODE_NORMAL: begin
                  regD = (packEn && !useCin) ? inD : cascOut; // [RULE3]
               end
               `LCC_MODE_ARITH: begin
                  regD = cascOut; // [RULE9]
               end
               `LCC_MODE_COUNTER: begin
                  regD = cntNext; // [RULE18]
               end
               default: begin
                  regD = cascOut;
               end
            endcase
         end

         // Selected cluster clock enable
         assign selCe = clusterCe[cfg[`LCC_CESEL_BIT]]; // [RULE4]

         // Cell register
         always @(posedge sys_clk) begin
            if (!nrst) begin
               cell_q <= 1'b0;
            end else if (clkEn && selCe) begin // [RULE17] [RULE13]
               if (syncClr) begin
                  cell_q <= 1'b0; // [RULE7] [RULE18]
               end else if (syncLoad) begin
                  cell_q <= inC; // [RULE7] [RULE18]
               end else begin
                  cell_q <= regD;
               end
            end
         end

         // Both copies driven at once
         assign cellComb[i] = cascOut; // [RULE12]
         assign cellReg[i]  = cell_q; // [RULE12]
      end
   endgenerate

endmodule // lcc_cluster

// [tb/lcc_nbr_model.sv]
// Neighbouring cell that feeds the cluster chains
`timescale 1ns/1ns
module lcc_nbr_model (
   // Operands of the previous cell
   input  logic opA,
   input  logic opB,
   // Chains into the cluster
   output logic carryIn,
   output logic cascadeIn
);
   // Adder cell with carry-in low; its result goes into the cascade
   assign carryIn   = opA & opB;
   assign cascadeIn = opA ^ opB;
endmodule // lcc_nbr_model

// [tb/lcc_cluster_properties.sv]
// Port assertions of the logic cluster
`timescale 1ns/1ns
module lcc_cluster_checker #(parameter NCELLS = 10) (
   // Clock and bus
   input logic              sys_clk,
   input logic              nrst,
   input logic              clkEn,
   input logic              regRd,
   input logic [4:0]        regAddr,
   input logic [31:0]       regRdata,
   // Cluster
   input logic [1:0]        clusterCe,
   input logic              syncClr,
   input logic              syncLoad,
   input logic              carryOut,
   input logic [NCELLS-1:0] cellInputC,
   input logic [NCELLS-1:0] cellReg
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   wire allEn = clkEn & (&clusterCe);
   a_ce_hold: assert property (
      clusterCe == 2'h0 |=> $stable(cellReg))
      else $error("register moved with enables low");
   a_freeze_all: assert property (
      !clkEn |=> $stable(cellReg) && $stable(regRdata))
      else $error("state moved while frozen");
   a_clear_all: assert property (
      allEn && syncClr |=> cellReg == '0)
      else $error("clear missed a register");
   a_clear_stays: assert property (
      allEn && syncClr ##1 !clkEn |=> cellReg == '0)
      else $error("cleared value lost while frozen");
   a_load_all: assert property (
      allEn && syncLoad && !syncClr |=> cellReg == $past(cellInputC))
      else $error("load value wrong");
   a_idle_zero: assert property (clkEn && !regRd |=> regRdata == '0)
      else $error("read data without read");
   a_stat_read: assert property (
      clkEn && regRd && regAddr == 5'h10 |=> regRdata[NCELLS-1:0] ==
      $past(cellReg) && regRdata[16] == $past(carryOut))
      else $error("status word wrong");
   a_unmapped_zero: assert property (
      clkEn && regRd && regAddr == 5'h1f |=> regRdata == '0)
      else $error("unmapped read not zero");
   c_count: cover property (allEn && !syncClr && !syncLoad);
   c_load: cover property (allEn && syncLoad && !syncClr);
   c_stat: cover property (regRd && regAddr == 5'h10);
endmodule // lcc_cluster_checker
bind lcc_cluster lcc_cluster_checker #(.NCELLS(NCELLS)) lcc_cluster_checker_i (
   .sys_clk(sys_clk), .nrst(nrst), .clkEn(clkEn), .regRd(regRd),
   .regAddr(regAddr), .regRdata(regRdata), .clusterCe(clusterCe),
   .syncClr(syncClr), .syncLoad(syncLoad), .carryOut(carryOut),
   .cellInputC(cellInputC), .cellReg(cellReg));

// [tb/test_logic_cell_operating_modes.sv]
// Self-checking bench of the logic cluster
`timescale 1ns/1ns
module test_logic_cell_operating_modes;
   localparam NC = 4;
   logic          sys_clk = 0, nrst = 0, clkEn = 1, regWr = 0, regRd = 0;
   logic [4:0]    regAddr = 0;
   logic [31:0]   regWdata = 0, regRdata;
   logic [1:0]    clusterCe = 0;
   logic          syncClr = 0, syncLoad = 0, opA = 0, opB = 0;
   logic [NC-1:0] ia = 0, ib = 0, ic = 0, id = 0, cellComb, cellReg, q;
   logic          carryIn, cascadeIn, carryOut, cascadeOut;
   int            n_errors = 0, n_compared = 0;
   lcc_cluster #(.NCELLS(NC)) lcc_cluster_i (
      .sys_clk(sys_clk), .nrst(nrst), .clkEn(clkEn), .regAddr(regAddr),
      .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
      .regRdata(regRdata), .clusterCe(clusterCe), .syncClr(syncClr),
      .syncLoad(syncLoad), .cellInputA(ia), .cellInputB(ib),
      .cellInputC(ic), .cellInputD(id), .carryIn(carryIn),
      .cascadeIn(cascadeIn), .cellComb(cellComb), .cellReg(cellReg),
      .carryOut(carryOut), .cascadeOut(cascadeOut));
   lcc_nbr_model lcc_nbr_model_i (.opA(opA), .opB(opB),
      .carryIn(carryIn), .cascadeIn(cascadeIn));
   initial forever #2 sys_clk = ~sys_clk;
   ////////////////////////////////////////////////////////////////////////
   task automatic report_and_stop;
      if (n_errors == 0 && n_compared > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
      n_compared++;
      if (s !== e) begin
         n_errors++;
         $display("BAD %s exp %h got %h", nm, e, s);
      end
   endtask
   task automatic wr(logic [4:0] a, logic [31:0] d);
      @(posedge sys_clk);
      regWr <= 1;
      regAddr <= a;
      regWdata <= d;
      @(posedge sys_clk);
      regWr <= 0;
   endtask
   task automatic rd(logic [4:0] a, output logic [31:0] d);
      @(posedge sys_clk);
      regRd <= 1;
      regAddr <= a;
      @(posedge sys_clk);
      regRd <= 0;
      #1 d = regRdata;
   endtask
   task automatic cfgall(logic [23:0] w);
      for (int i = 0; i < NC; i++) wr(5'(i), {8'h0, w});
   endtask
   ////////////////////////////////////////////////////////////////////////
   function automatic logic [NC+1:0] comb(logic [23:0] w,
      logic [NC-1:0] a, b, c, d, logic ci, cs);
      logic r, co;
      for (int i = 0; i < NC; i++) begin
         co = 0;
         if (w[17:16] == 2'h1) begin
            r = w[{1'b0, ci, b[i], a[i]}];
            co = w[{1'b1, ci, b[i], a[i]}];
         end else r = w[{d[i], w[18] ? ci : c[i], b[i], a[i]}];
         cs = w[21] ? r & cs : r;
         comb[i] = cs;
         ci = co;
      end
      comb[NC+1:NC] = {cs, ci};
   endfunction
   function automatic logic [NC-1:0] cnt(logic [NC-1:0] q, a, b);
      logic ci, t;
      ci = 1;
      for (int i = 0; i < NC; i++) begin
         t = ((i == 1) | a[i]) & ci;
         cnt[i] = q[i] ^ t;
         ci = ((i == 1) | b[i]) ? t & q[i] : t & ~q[i];
      end
   endfunction
   ////////////////////////////////////////////////////////////////////////
   initial begin
      #20000;
      n_errors++;
      report_and_stop;
   end
   initial begin
      logic [31:0] d;
      logic [23:0] w;
      logic [NC+1:0] e;
      logic [NC-1:0] p;
      d = $urandom(52000);
      repeat (12) @(posedge sys_clk);
      nrst <= 1;
      clusterCe <= 2'h3;
      rd(5'h00, d);
      chk("cfg reset", d, 0);
      rd(5'h10, d);
      chk("status reset", d, 0);
      rd(5'h1f, d);
      chk("unmapped", d, 0);
      for (int k = 0; k < 40; k++) begin
         w = (k < 4) ? 24'h01e896 : 24'($urandom) & 24'h25ffff;
         if (k % 8 == 7) w[17:16] = 2'h3;
         cfgall(w);
         rd(5'(k % NC), d);
         chk("cfg word", d, {8'h0, w});
         for (int j = 0; j < 4; j++) begin
            @(posedge sys_clk);
            {ia, ib, ic, id, opA, opB} <= 18'($urandom);
            #1 e = comb(w, ia, ib, ic, id, opA & opB, opA ^ opB);
            chk("comb", {cascadeOut, carryOut, cellComb}, e);
            if (k < 4) chk("add", {carryOut, cellComb}, ia + ib + opA * opB);
            if (j > 0 && !w[21]) chk("reg copy", cellReg, p);
            p = e[NC-1:0];
         end
      end
      cfgall(24'h080000);
      id <= NC'($urandom);
      @(posedge sys_clk);
      #1 chk("packed", cellReg, id);
      cfgall(24'h0cffff);
      id <= 0;
      @(posedge sys_clk);
      #1 chk("no pack", cellReg, {NC{1'b1}});
      wr(5'h00, 32'h405555);
      wr(5'h01, 32'h405555);
      ia <= {NC{1'b1}};
      @(posedge sys_clk);
      #1 p = cellReg;
      chk("second cell", p[1], 0);
      @(posedge sys_clk);
      #1 chk("feedback", cellReg[1:0], {1'b0, ~p[0]});
      for (int i = 0; i < NC; i++)
         wr(5'(i), 32'h20000 | (i[0] << 20) | ((i == 0) << 23));
      syncClr <= 1;
      @(posedge sys_clk);
      clkEn <= 0;
      @(posedge sys_clk);
      q = 0;
      repeat (300) begin
         {ia, ib, ic, clusterCe} <= 14'($urandom);
         syncClr <= ($urandom % 8 == 0);
         syncLoad <= ($urandom % 5 == 0);
         clkEn <= ($urandom % 8 != 0);
         for (int s = 0; s < 2; s++) begin
            #1 p = cnt(q, ia, ib);
            for (int i = 0; i < NC; i++)
               if (clkEn && clusterCe[i % 2])
                  q[i] = syncClr ? 1'b0 : syncLoad ? ic[i] : p[i];
            @(posedge sys_clk);
            if (s == 0) #1 chk("counter", cellReg, q);
         end
      end
      clusterCe <= 0;
      clkEn <= 1;
      rd(5'h10, d);
      chk("status", d[NC-1:0], q);
      report_and_stop;
   end
endmodule // test_logic_cell_operating_modes
